//--- rtl/pcx_exec.sv
`timescale 1ns/10ps
`include "pcx_params.svh"
module pcx_exec (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // program memory, data valid one clock after address
    output logic [15:0] code_addr_o,
    input wire logic [7:0] code_data_i,
    // core context
    input wire logic [1:0] bank_i,
    input wire pcx_pkg::pcx_idx_wr_t idx_wr_i,
    input wire pcx_pkg::pcx_port_wr_t p2_wr_i,
    input wire pcx_pkg::pcx_port_wr_t b_wr_i,
    // external data bus
    input wire logic [7:0] p0_i,
    output pcx_pkg::pcx_xbus_t xbus_o,
    // status
    output pcx_pkg::pcx_state_t state_o,
    output logic done_o,
    output logic illegal_o
);
    import pcx_pkg::*;

    logic [5:0] cnt_r;
    logic [5:0] last_r;
    logic [7:0] opc_r;
    pcx_cls_t cls_r;
    pcx_cls_t cls_nxt;
    logic [5:0] ncyc_nxt;
    logic [15:0] pc_r;
    logic [15:0] data_pointer_r;
    logic [7:0] acc_r;
    logic [7:0] b_r;
    logic [7:0] p2_latch_r;
    logic cy_r;
    logic ov_r;
    logic [7:0] idx_r [0:7];
    logic [7:0] p0_s1_r;
    logic [7:0] p0_s2_r;
    pcx_xbus_t bus_r;
    logic [15:0] code_addr_r;
    logic done_r;
    logic illegal_r;
    logic decoded_r;
    logic [15:0] prod;
    logic [15:0] table_addr;
    logic [7:0] ri_val;
    logic is_x;
    logic is_xdp;
    logic is_xwr;
    logic at_end;

    // datapath helpers
    assign prod = acc_r * b_r;
    assign table_addr = {8'h00, acc_r} +
        ((cls_r == PCX_CODE_TABLE_READ_PC) ? pc_r : data_pointer_r);
    assign ri_val = idx_r[{bank_i, opc_r[0]}];
    assign is_x = (cls_r == PCX_XRD_RI) || (cls_r == PCX_XWR_RI) ||
        (cls_r == PCX_XRD_DP) || (cls_r == PCX_XWR_DP);
    assign is_xdp = (cls_r == PCX_XRD_DP) || (cls_r == PCX_XWR_DP);
    assign is_xwr = (cls_r == PCX_XWR_RI) || (cls_r == PCX_XWR_DP);
    assign at_end = decoded_r && (cnt_r == last_r);

    // opcode decode to class and machine cycles
    always_comb begin
        cls_nxt = PCX_ILLEGAL;
        ncyc_nxt = `PCX_CYC_1;
        case (code_data_i)
            `PCX_OP_NOP: begin
                cls_nxt = PCX_NOP;
                ncyc_nxt = `PCX_CYC_1;
            end
            `PCX_OP_LD_DATA_POINTER: begin
                cls_nxt = PCX_LD_DATA_POINTER;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_CODE_TABLE_READ_DP: begin
                cls_nxt = PCX_CODE_TABLE_READ_DP;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_CODE_TABLE_READ_PC: begin
                cls_nxt = PCX_CODE_TABLE_READ_PC;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_XRD_R0, `PCX_OP_XRD_R1: begin
                cls_nxt = PCX_XRD_RI;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_XWR_R0, `PCX_OP_XWR_R1: begin
                cls_nxt = PCX_XWR_RI;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_XRD_DP: begin
                cls_nxt = PCX_XRD_DP;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_XWR_DP: begin
                cls_nxt = PCX_XWR_DP;
                ncyc_nxt = `PCX_CYC_2;
            end
            `PCX_OP_MUL: begin
                cls_nxt = PCX_MUL;
                ncyc_nxt = `PCX_CYC_4;
            end
            default: begin
                cls_nxt = PCX_ILLEGAL;
                ncyc_nxt = `PCX_CYC_1;
            end
        endcase
    end

    // instruction clock counter and decoded class
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= 6'd0;
            last_r <= 6'd0;
            decoded_r <= 1'b0;
            opc_r <= `PCX_RST_BYTE;
            cls_r <= PCX_NOP;
        end else if (at_end) begin
            cnt_r <= 6'd0;
            decoded_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 6'd1;
            if (cnt_r == `PCX_T_OPC) begin
                opc_r <= code_data_i;
                cls_r <= cls_nxt;
                last_r <= 6'(ncyc_nxt * `PCX_CLK_PER_MC - 6'd1);
                decoded_r <= 1'b1;
            end
        end
    end

    // program counter and code memory address
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_r <= `PCX_RST_PC;
            code_addr_r <= `PCX_RST_PC;
        end else if (cnt_r == 6'd0) begin
            code_addr_r <= pc_r;
        end else if (cnt_r == `PCX_T_OPC) begin
            pc_r <= pc_r + 16'd1;
        end else if (cnt_r == `PCX_T_EXE) begin
            if (cls_r == PCX_LD_DATA_POINTER) begin
                code_addr_r <= pc_r;
            end else if (cls_r == PCX_CODE_TABLE_READ_DP || cls_r == PCX_CODE_TABLE_READ_PC) begin
                code_addr_r <= table_addr;
            end
        end else if (cls_r == PCX_LD_DATA_POINTER) begin
            if (cnt_r == `PCX_T_B2 || cnt_r == `PCX_T_B3) begin
                pc_r <= pc_r + 16'd1;
            end else if (cnt_r == `PCX_T_A3) begin
                code_addr_r <= pc_r;
            end
        end
    end

    // data pointer load from instruction bytes
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_pointer_r <= 16'h0000;
        end else if (decoded_r && cls_r == PCX_LD_DATA_POINTER) begin
            if (cnt_r == `PCX_T_B2) begin
                data_pointer_r[15:8] <= code_data_i;
            end else if (cnt_r == `PCX_T_B3) begin
                data_pointer_r[7:0] <= code_data_i;
            end
        end
    end

    // accumulator, B and flags
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_r <= `PCX_RST_BYTE;
            b_r <= `PCX_RST_BYTE;
            cy_r <= 1'b0;
            ov_r <= 1'b0;
        end else begin
            // software load of B; a multiply result in the same clock wins
            if (b_wr_i.en) begin
                b_r <= b_wr_i.data;
            end
            if (decoded_r) begin
                if ((cls_r == PCX_CODE_TABLE_READ_DP || cls_r == PCX_CODE_TABLE_READ_PC) &&
                    cnt_r == `PCX_T_B2) begin
                    acc_r <= code_data_i;
                end else if ((cls_r == PCX_XRD_RI || cls_r == PCX_XRD_DP) &&
                    cnt_r == `PCX_T_STB_OFF) begin
                    acc_r <= p0_s2_r;
                end else if (cls_r == PCX_MUL && cnt_r == `PCX_T_EXE) begin
                    acc_r <= prod[7:0];
                    b_r <= prod[15:8];
                    ov_r <= (prod[15:8] != 8'h00);
                    cy_r <= 1'b0;
                end
            end
        end
    end

    // index registers, four banks of two
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 8; i++) begin
                idx_r[i] <= `PCX_RST_BYTE;
            end
        end else if (idx_wr_i.en) begin
            idx_r[idx_wr_i.sel] <= idx_wr_i.data;
        end
    end

    // high port latch, written only by software
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            p2_latch_r <= `PCX_RST_P2;
        end else if (p2_wr_i.en) begin
            p2_latch_r <= p2_wr_i.data;
        end
    end

    // low port input synchroniser
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            p0_s1_r <= 8'h00;
            p0_s2_r <= 8'h00;
        end else begin
            p0_s1_r <= p0_i;
            p0_s2_r <= p0_s1_r;
        end
    end

    // external bus sequencing
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bus_r.ale <= 1'b0;
            bus_r.rd_n <= 1'b1;
            bus_r.wr_n <= 1'b1;
            bus_r.p0_oe <= 1'b0;
            bus_r.p0 <= 8'h00;
            bus_r.p2 <= `PCX_RST_P2;
        end else begin
            bus_r.p2 <= p2_latch_r;
            if (decoded_r && is_x) begin
                if (is_xdp && cnt_r >= `PCX_T_ALE_ON &&
                    cnt_r < `PCX_T_BUS_END) begin
                    bus_r.p2 <= data_pointer_r[15:8];
                end
                if (cnt_r == `PCX_T_ALE_ON) begin
                    bus_r.ale <= 1'b1;
                    bus_r.p0_oe <= 1'b1;
                    bus_r.p0 <= is_xdp ? data_pointer_r[7:0] : ri_val;
                end else if (cnt_r == `PCX_T_ALE_OFF) begin
                    bus_r.ale <= 1'b0;
                end else if (cnt_r == `PCX_T_STB_ON) begin
                    bus_r.p0_oe <= is_xwr;
                    bus_r.p0 <= is_xwr ? acc_r : 8'h00;
                    bus_r.rd_n <= is_xwr;
                    bus_r.wr_n <= ~is_xwr;
                end else if (cnt_r == `PCX_T_STB_OFF) begin
                    bus_r.rd_n <= 1'b1;
                    bus_r.wr_n <= 1'b1;
                end else if (cnt_r == `PCX_T_BUS_END) begin
                    bus_r.p0_oe <= 1'b0;
                end
            end
        end
    end

    // completion and illegal opcode pulses
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            done_r <= at_end;
            illegal_r <= at_end && (cls_r == PCX_ILLEGAL);
        end
    end

    // outputs straight from flops
    assign code_addr_o = code_addr_r;
    assign xbus_o = bus_r;
    assign state_o = '{pc: pc_r, data_pointer: data_pointer_r, acc: acc_r, b: b_r,
        p2_latch: p2_latch_r, cy: cy_r, ov: ov_r};
    assign done_o = done_r;
    assign illegal_o = illegal_r;
endmodule

//--- common/pcx_params.svh
`ifndef PCX_PARAMS_SVH
`define PCX_PARAMS_SVH
`define PCX_OP_NOP 8'h00
`define PCX_OP_LD_DATA_POINTER 8'h90
`define PCX_OP_CODE_TABLE_READ_DP 8'h93
`define PCX_OP_CODE_TABLE_READ_PC 8'h83
`define PCX_OP_XRD_R0 8'he2
`define PCX_OP_XRD_R1 8'he3
`define PCX_OP_XWR_R0 8'hf2
`define PCX_OP_XWR_R1 8'hf3
`define PCX_OP_XRD_DP 8'he0
`define PCX_OP_XWR_DP 8'hf0
`define PCX_OP_MUL 8'ha4
// clocks per machine cycle and step positions inside an instruction
`define PCX_CLK_PER_MC 6'd12
`define PCX_CYC_1 6'd1
`define PCX_CYC_2 6'd2
`define PCX_CYC_4 6'd4
`define PCX_T_OPC 6'd2
`define PCX_T_EXE 6'd3
`define PCX_T_B2 6'd5
`define PCX_T_A3 6'd6
`define PCX_T_B3 6'd8
`define PCX_T_ALE_ON 6'd3
`define PCX_T_ALE_OFF 6'd5
`define PCX_T_STB_ON 6'd6
`define PCX_T_STB_OFF 6'd11
`define PCX_T_BUS_END 6'd12
`define PCX_RST_PC 16'h0000
`define PCX_RST_BYTE 8'h00
`define PCX_RST_P2 8'hff
`endif

//--- common/pcx_pkg.sv
package pcx_pkg;
    typedef enum logic [3:0] {
        PCX_NOP, PCX_LD_DATA_POINTER, PCX_CODE_TABLE_READ_DP, PCX_CODE_TABLE_READ_PC, PCX_XRD_RI,
        PCX_XWR_RI, PCX_XRD_DP, PCX_XWR_DP, PCX_MUL, PCX_ILLEGAL
    } pcx_cls_t;
    // external bus pins driven by the core
    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic p0_oe;
        logic [7:0] p0;
        logic [7:0] p2;
    } pcx_xbus_t;
    // index register write from the rest of the core
    typedef struct packed {
        logic en;
        logic [2:0] sel;
        logic [7:0] data;
    } pcx_idx_wr_t;
    // software write to the high-address port latch or to B
    typedef struct packed {
        logic en;
        logic [7:0] data;
    } pcx_port_wr_t;
    // architectural state seen by the rest of the core
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] data_pointer;
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] p2_latch;
        logic cy;
        logic ov;
    } pcx_state_t;
endpackage

//--- tb/pcx_exec_properties.sv
`timescale 1ns/10ps
module pcx_exec_chk (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // watched ports
    input wire pcx_pkg::pcx_port_wr_t p2_wr_i,
    input wire logic [7:0] p0_i,
    input wire pcx_pkg::pcx_xbus_t xbus_o,
    input wire pcx_pkg::pcx_state_t state_o,
    input wire logic done_o
);
    import pcx_pkg::*;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    // bus strobes
    chk_ale_width: assert property (
        $rose(xbus_o.ale) |=> xbus_o.ale ##1 !xbus_o.ale)
        else $error("latch strobe width wrong");
    chk_addr_hold: assert property (
        $fell(xbus_o.ale) |-> xbus_o.p0_oe && $stable(xbus_o.p0))
        else $error("address not held past latch strobe");
    chk_read_width: assert property (
        $fell(xbus_o.rd_n) |-> !xbus_o.rd_n[*5] ##1 xbus_o.rd_n)
        else $error("read strobe width wrong");
    chk_write_data: assert property (
        $fell(xbus_o.wr_n) |->
        (!xbus_o.wr_n && xbus_o.p0_oe && xbus_o.p0 == state_o.acc)[*5]
        ##1 xbus_o.wr_n)
        else $error("write cycle data or width wrong");
    chk_read_capture: assert property (
        $rose(xbus_o.rd_n) |-> state_o.acc == $past(p0_i))
        else $error("read byte not loaded");
    // state relations
    chk_latch_kept: assert property (
        !$past(p2_wr_i.en) |-> $stable(state_o.p2_latch))
        else $error("port latch changed without a write");
    chk_done_gap: assert property (
        done_o |=> !done_o[*8])
        else $error("instructions shorter than a cycle");
    chk_mul_flags: assert property (
        !state_o.cy && (!$changed(state_o.ov) ||
        state_o.ov == (state_o.b != 8'h00)))
        else $error("multiply flags wrong");
endmodule

bind pcx_exec pcx_exec_chk i_pcx_exec_chk (
    .sys_clk_i, .reset_i, .p2_wr_i, .p0_i, .xbus_o, .state_o, .done_o
);

//--- tb/pcx_xram.sv
`timescale 1ns/10ps
module pcx_xram (
    // clock
    input wire logic sys_clk_i,
    // core bus pins
    input wire pcx_pkg::pcx_xbus_t xbus_i,
    // low port level seen by the core
    output logic [7:0] p0_o
);
    import pcx_pkg::*;
    logic [7:0] mem [0:65535];
    logic [15:0] addr_r = 16'h0000;
    // latch full address while strobe high, store on write strobe
    always @(posedge sys_clk_i) begin
        if (xbus_i.ale) addr_r <= {xbus_i.p2, xbus_i.p0};
        if (!xbus_i.wr_n) mem[addr_r] <= xbus_i.p0;
    end
    // wire level: core drives, memory answers reads, else the inverted memory byte
    always_comb begin
        if (xbus_i.p0_oe) p0_o = xbus_i.p0;
        else if (!xbus_i.rd_n) p0_o = mem[addr_r];
        else p0_o = ~mem[addr_r];
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pcx_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] code_addr_o;
    logic [7:0] code_data_i = 8'h00;
    logic [1:0] bank_i = 2'h0;
    pcx_idx_wr_t idx_wr_i = '0;
    pcx_port_wr_t p2_wr_i = '0;
    pcx_port_wr_t b_wr_i = '0;
    logic [7:0] p0_i;
    pcx_xbus_t xbus_o;
    pcx_state_t state_o;
    pcx_state_t exp_s;
    logic done_o;
    logic illegal_o;
    logic [7:0] rom [0:65535];
    logic [7:0] prog [0:14] = '{8'h00, 8'h90, 8'h12, 8'hf0, 8'h93, 8'h93,
        8'h83, 8'hf0, 8'he2, 8'hf3, 8'he0, 8'ha4, 8'he3, 8'ha5, 8'h00};
    int error_cnt = 0;
    int tests_run = 0;
    int ncyc;

    pcx_exec i_pcx_exec (.sys_clk_i, .reset_i, .code_addr_o, .code_data_i,
        .bank_i, .idx_wr_i, .p2_wr_i, .b_wr_i, .p0_i, .xbus_o, .state_o,
        .done_o,
        .illegal_o);
    pcx_xram i_pcx_xram (.sys_clk_i, .xbus_i(xbus_o), .p0_o(p0_i));

    // clock
    always #20 sys_clk_i = ~sys_clk_i;
    // program memory answers shortly after each address update
    always @(posedge sys_clk_i) begin
        #1;
        code_data_i = rom[code_addr_o];
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // wait for the next completion, counting clocks since the task was called
    task automatic step();
        ncyc = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            ncyc++;
        end while (done_o !== 1'b1 && ncyc < 100);
        chk(done_o, 1'b1);
    endtask

    task automatic t_nop();
        @(posedge sys_clk_i);
        #1;
        idx_wr_i = '{1'b1, 3'h0, 8'h40};
        p2_wr_i = '{1'b1, 8'h33};
        @(posedge sys_clk_i);
        #1;
        idx_wr_i = '{1'b1, 3'h3, 8'h41};
        p2_wr_i = '0;
        @(posedge sys_clk_i);
        #1;
        idx_wr_i = '0;
        step();
        exp_s.pc = 16'h0001;
        exp_s.p2_latch = 8'h33;
        chk(state_o, exp_s);
        chk(xbus_o.p2, 8'h33);
    endtask

    task automatic t_load();
        step();
        chk(ncyc, 24);
        exp_s.pc = 16'h0004;
        exp_s.data_pointer = 16'h12f0;
        chk(state_o, exp_s);
    endtask

    task automatic t_table();
        step();
        chk(ncyc, 24);
        exp_s.pc = 16'h0005;
        exp_s.acc = 8'h20;
        chk(state_o, exp_s);
        step();
        exp_s.pc = 16'h0006;
        exp_s.acc = 8'hff;
        chk(state_o, exp_s);
        step();
        exp_s.pc = 16'h0007;
        exp_s.acc = 8'h5a;
        chk(state_o, exp_s);
    endtask

    task automatic t_ext();
        step();
        chk(ncyc, 24);
        exp_s.pc = 16'h0008;
        chk(state_o, exp_s);
        chk(i_pcx_xram.mem[16'h12f0], 8'h5a);
        step();
        chk(ncyc, 24);
        exp_s.pc = 16'h0009;
        exp_s.acc = 8'h81;
        chk(state_o, exp_s);
        bank_i = 2'h1;
        step();
        exp_s.pc = 16'h000a;
        chk(i_pcx_xram.mem[16'h3341], 8'h81);
        step();
        exp_s.pc = 16'h000b;
        exp_s.acc = 8'h5a;
        chk(state_o, exp_s);
    endtask

    task automatic t_mul_tail();
        b_wr_i = '{1'b1, 8'h30};
        @(posedge sys_clk_i);
        #1;
        b_wr_i = '0;
        step();
        chk(ncyc + 1, 48);
        exp_s.pc = 16'h000c;
        exp_s.acc = 8'he0;
        exp_s.b = 8'h10;
        exp_s.ov = 1'b1;
        chk(state_o, exp_s);
        chk(state_o.ov, 1'b1);
        step();
        exp_s.pc = 16'h000d;
        exp_s.acc = 8'h81;
        chk(state_o, exp_s);
        step();
        chk(illegal_o, 1'b1);
        step();
        chk(ncyc, 12);
        exp_s.pc = 16'h000f;
        chk(state_o, exp_s);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #(40 * 3000);
        error_cnt++;
        $display("Error at %0t: run did not complete", $time);
        finish_test();
    end

    // main sequence
    initial begin
        rom = '{default: 8'h00};
        foreach (prog[k]) rom[k] = prog[k];
        rom[16'h12f0] = 8'h20;
        rom[16'h1310] = 8'hff;
        rom[16'h0106] = 8'h5a;
        i_pcx_xram.mem[16'h3340] = 8'h81;
        exp_s = '0;
        exp_s.p2_latch = 8'hff;
        repeat (20) @(posedge sys_clk_i);
        #1;
        reset_i = 1'b0;
        t_nop();
        t_load();
        t_table();
        t_ext();
        t_mul_tail();
        finish_test();
    end
endmodule
